// >>> logic/dac_consts.svh
// Behaviour
// (R01) Corrected code = code*(gain+2)/2^n + offset - half
// (R02) Resolution n is 14 or 12 by variant
// (R03) Gain resets to 0x3FFE or 0xFFE, unity
// (R04) Gain coefficient LSB always reads zero
// (R05) Offset resets to 0x2000 or 0x800, zero
// (R06) Select 11 code, 10 offset, 01 gain, 00 special
// (R07) Internal data bus is 14 or 12 bits
// (R08) Corrected code is straight binary to converter
// (R09) Offset coefficient is offset binary around midscale
// (R10) Gain scales linearly with coefficient value
// (R11) Sixteen or eight independent channels by variant
// (R12) Each channel keeps its own gain and offset
// (R13) Input stage separate; load pin updates all outputs
// (R14) Interface select pin chooses serial or two-wire
// (R15) Serial front end idles until frame sync falls
// (R16) Select low means two-wire, high means serial
// (R17) 24-bit word: bank, rw, 00, addr, sel, data
// (R18) Clamp result to range, truncate gain fraction
// (R19) Recompute corrected code after any coefficient write
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

// Serial word layout, bit positions from the top
`define WORD_BITS 5'h18
`define F_BANK 5'h17
`define F_RW 5'h16
`define F_ADDR_HI 5'h13
`define F_ADDR_LO 5'h10
`define F_SEL_HI 5'h0F
`define F_SEL_LO 5'h0E
`define F_DATA_HI 5'h0D

// Register select encodings
`define SEL_INPUT_CODE 2'h3
`define SEL_OFFSET_CODE 2'h2
`define SEL_GAIN_CODE 2'h1
`define SEL_SPECIAL_CODE 2'h0

// Coefficient reset values per resolution
`define GAIN_RST_14 14'h3FFE
`define GAIN_RST_12 12'hFFE
`define OFF_RST_14 14'h2000
`define OFF_RST_12 12'h800

`endif

// >>> logic/dac_pkg.sv
`include "dac_consts.svh"

package dac_pkg;

  // Register select field of a serial word
  typedef enum logic [1:0]
  {
    SEL_SPECIAL = `SEL_SPECIAL_CODE,
    SEL_GAIN = `SEL_GAIN_CODE,
    SEL_OFFSET = `SEL_OFFSET_CODE,
    SEL_INPUT = `SEL_INPUT_CODE
  } reg_sel_t;

  // Core sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_CALC} core_state_t;

endpackage : dac_pkg

// >>> logic/word_if.sv
`timescale 1ns/1ns
`default_nettype none

// Carries a received word from the link domain to the core
interface word_if;
  logic [23:0] word;
  logic tgl;
  modport rx (output word, output tgl);
  modport core (input word, input tgl);
endinterface : word_if

`default_nettype wire

// >>> logic/serial_rx.sv
`timescale 1ns/1ns
`default_nettype none
`include "dac_consts.svh"

module serial_rx
(
  input wire logic rstn,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_data,
  word_if.rx lnk
);
  import dac_pkg::*;

  logic [4:0] bit_cnt_r;
  logic [22:0] shift_r;

  ////////////////////////////////////////////////////////////////
  // Bit counter, cleared while frame sync is high; a short frame is dropped
  always_ff @(negedge sclk or negedge rstn or posedge frame_sync_n)
  begin
    if (!rstn)
      bit_cnt_r <= 5'h00;
    else if (frame_sync_n)
      bit_cnt_r <= 5'h00; // R15
    else if (bit_cnt_r != `WORD_BITS)
      bit_cnt_r <= bit_cnt_r + 5'h01;
  end

  // Shifter only toggles inside a frame, keeping the link quiet otherwise
  always_ff @(negedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_r <= 23'h000000;
      lnk.word <= 24'h000000;
      lnk.tgl <= 1'b0;
    end
    else if (!frame_sync_n && bit_cnt_r != `WORD_BITS) // R15
    begin
      shift_r <= {shift_r[21:0], serial_data};
      // Word is held stable until the next full frame, then the toggle flips
      if (bit_cnt_r == `WORD_BITS - 5'h01)
      begin
        lnk.word <= {shift_r, serial_data}; // R17
        lnk.tgl <= ~lnk.tgl;
      end
    end
  end

  a_frame_idle: assert property (@(negedge sclk) disable iff (!rstn) // R15
    frame_sync_n |-> bit_cnt_r == 5'h00)
    else $error("bit counter running outside a frame");

endmodule : serial_rx

`default_nettype wire

// >>> logic/gain_offset_calc.sv
`timescale 1ns/1ns
`default_nettype none

module gain_offset_calc
#(
  parameter int RES = 14
)
(
  input wire logic [RES-1:0] code,
  input wire logic [RES-1:0] gain,
  input wire logic [RES-1:0] offset,
  output logic [RES-1:0] corrected
);
  localparam logic [RES+2:0] HALF = (RES+3)'(1) << (RES - 1);
  localparam logic [RES+2:0] FULL = (RES+3)'({RES{1'b1}});

  logic [RES:0] gain_p2;
  logic [2*RES:0] prod;
  logic signed [RES+2:0] sum;

  // Gain product kept whole; dropping low bits truncates toward zero
  always_comb
  begin
    gain_p2 = (RES+1)'(gain) + (RES+1)'(2); // R10
    prod = (2*RES+1)'(code) * (2*RES+1)'(gain_p2); // R01
    sum = $signed((RES+3)'(prod[2*RES:RES])) + $signed((RES+3)'(offset)) // R02
      - $signed(HALF); // R09
    if (sum < 0)
      corrected = '0; // R18
    else if (sum > $signed(FULL))
      corrected = {RES{1'b1}}; // R18
    else
      corrected = sum[RES-1:0]; // R08
  end

endmodule : gain_offset_calc

`default_nettype wire

// >>> logic/dac_front.sv
`timescale 1ns/1ns
`default_nettype none
`include "dac_consts.svh"

module dac_front
#(
  parameter int RES = 14,
  parameter int CHANNELS = 16
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_data,
  input wire logic iface_select,
  input wire logic load_outputs_n,
  output logic [CHANNELS*RES-1:0] dac_code,
  output logic serial_mode,
  output logic special_strobe,
  output logic [3:0] special_addr,
  output logic [RES-1:0] special_data
);
  import dac_pkg::*;

  // Reset values follow the resolution of the variant
  localparam logic [RES-1:0] GAIN_RST = (RES == 14) ? RES'(`GAIN_RST_14) :
    RES'(`GAIN_RST_12); // R03
  localparam logic [RES-1:0] OFF_RST = (RES == 14) ? RES'(`OFF_RST_14) :
    RES'(`OFF_RST_12); // R05

  ////////////////////////////////////////////////////////////////
  // Channel storage

  logic [RES-1:0] code_r [CHANNELS];
  logic [RES-1:0] gain_r [CHANNELS];
  logic [RES-1:0] off_r [CHANNELS];
  logic [RES-1:0] corr_r [CHANNELS];
  logic [RES-1:0] dac_r [CHANNELS];

  ////////////////////////////////////////////////////////////////
  // Link domain receiver

  word_if lnk ();

  serial_rx u_rx
  (
    .rstn(rstn),
    .sclk(sclk),
    .frame_sync_n(frame_sync_n),
    .serial_data(serial_data),
    .lnk(lnk.rx)
  );

  ////////////////////////////////////////////////////////////////
  // Crossings into the system clock

  logic tgl_s1, tgl_s2, tgl_s3;
  logic mode_s1, mode_s2;
  logic load_s1, load_s2;
  logic word_evt;

  // Toggle event crosses through two flops; the third only marks the edge
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end
    else
    begin
      tgl_s1 <= lnk.tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign word_evt = tgl_s2 ^ tgl_s3;

  // Interface select pin, a static strap but sampled safely anyway
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end
    else
    begin
      mode_s1 <= iface_select;
      mode_s2 <= mode_s1;
    end
  end

  assign serial_mode = mode_s2; // R16

  // Load pin synchroniser; idle level is high
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      load_s1 <= 1'b1;
      load_s2 <= 1'b1;
    end
    else
    begin
      load_s1 <= load_outputs_n;
      load_s2 <= load_s1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Word capture and decode

  logic [23:0] word_r;
  logic [3:0] ch_addr;
  logic [RES-1:0] data_w;
  logic ch_ok;
  logic is_write;
  reg_sel_t sel_w;

  // Word is stable in the link domain well before the toggle arrives here
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      word_r <= 24'h000000;
    else if (word_evt)
      word_r <= lnk.word; // R17
  end

  // Data is MSB aligned; twelve-bit parts drop the trailing two bits
  assign data_w = word_r[`F_DATA_HI -: RES]; // R07
  assign ch_addr = word_r[`F_ADDR_HI:`F_ADDR_LO];
  assign sel_w = reg_sel_t'(word_r[`F_SEL_HI:`F_SEL_LO]);
  assign is_write = ~word_r[`F_RW];
  assign ch_ok = 32'(ch_addr) < CHANNELS; // R11

  ////////////////////////////////////////////////////////////////
  // Sequencer

  core_state_t state_r, state_nxt;

  // Words are only taken while the serial interface is selected
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (word_evt && mode_s2)
          state_nxt = ST_WRITE; // R14
      ST_WRITE:
        state_nxt = ST_CALC;
      ST_CALC:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////
  // Register writes, routed by the select field

  logic wr_ok;

  assign wr_ok = (state_r == ST_WRITE) && is_write && ch_ok;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        code_r[i] <= '0;
        gain_r[i] <= GAIN_RST; // R03
        off_r[i] <= OFF_RST; // R05
      end
    end
    else if (wr_ok)
    begin
      if (sel_w == SEL_INPUT)
        code_r[ch_addr] <= data_w; // R06
      else if (sel_w == SEL_OFFSET)
        off_r[ch_addr] <= data_w; // R12
      else if (sel_w == SEL_GAIN)
        gain_r[ch_addr] <= {data_w[RES-1:1], 1'b0}; // R04
    end
  end

  // Special function words are handed out, their contents live elsewhere
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      special_strobe <= 1'b0;
      special_addr <= 4'h0;
      special_data <= '0;
    end
    else
    begin
      special_strobe <= (state_r == ST_WRITE) && is_write && (sel_w == SEL_SPECIAL);
      if ((state_r == ST_WRITE) && is_write && (sel_w == SEL_SPECIAL))
      begin
        special_addr <= ch_addr; // R06
        special_data <= data_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Correction, one shared datapath for all channels

  logic [RES-1:0] calc_code;

  // One multiplier is shared; a word takes three cycles, far shorter than a frame
  gain_offset_calc #(.RES(RES)) u_calc
  (
    .code(code_r[ch_addr]),
    .gain(gain_r[ch_addr]),
    .offset(off_r[ch_addr]),
    .corrected(calc_code)
  );

  // Corrected code is refreshed after every write that touches the channel
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < CHANNELS; i++)
        corr_r[i] <= '0;
    end
    else if (state_r == ST_CALC && ch_ok)
      corr_r[ch_addr] <= calc_code; // R19
  end

  ////////////////////////////////////////////////////////////////
  // Output stage, updated together while the load pin is low

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < CHANNELS; i++)
        dac_r[i] <= '0;
    end
    else if (!load_s2)
    begin
      for (int i = 0; i < CHANNELS; i++)
        dac_r[i] <= corr_r[i]; // R13
    end
  end

  // Flatten the output stage onto the port
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_out
      assign dac_code[g*RES +: RES] = dac_r[g]; // R08
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Checks

  logic touched_r;

  // Marks that a write word of any select has reached a valid channel since reset
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      touched_r <= 1'b0;
    else if (wr_ok)
      touched_r <= 1'b1;
  end

  a_gain_reset_value: assert property (@(posedge sys_clk) disable iff (!rstn) // R03
    !touched_r |-> gain_r[0] == GAIN_RST && gain_r[CHANNELS-1] == GAIN_RST)
    else $error("gain coefficient lost its reset value");

  a_offset_reset_value: assert property (@(posedge sys_clk) disable iff (!rstn) // R05
    !touched_r |-> off_r[0] == OFF_RST && off_r[CHANNELS-1] == OFF_RST)
    else $error("offset coefficient lost its reset value");

  a_gain_lsb_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // R04
    wr_ok && sel_w == SEL_GAIN |=> gain_r[$past(ch_addr)][0] == 1'b0)
    else $error("gain coefficient LSB not zero");

  a_code_route: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
    wr_ok && sel_w == SEL_INPUT |=> code_r[$past(ch_addr)] == $past(data_w))
    else $error("input code not stored at addressed channel");

  a_offset_isolated: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
    wr_ok && sel_w == SEL_OFFSET && ch_addr != 4'h0 |=> $stable(off_r[0]))
    else $error("offset write disturbed another channel");

  a_mode_gate: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    state_r == ST_IDLE && word_evt && !mode_s2 |=> state_r == ST_IDLE)
    else $error("word taken while two-wire mode selected");

  a_word_to_calc: assert property (@(posedge sys_clk) disable iff (!rstn) // R19
    state_r == ST_IDLE && word_evt && mode_s2 |=> state_r == ST_WRITE ##1
      state_r == ST_CALC ##1 state_r == ST_IDLE)
    else $error("word not processed in three cycles");

  a_corr_stored: assert property (@(posedge sys_clk) disable iff (!rstn) // R19
    state_r == ST_CALC && ch_ok |=> corr_r[$past(ch_addr)] == $past(calc_code))
    else $error("corrected code not stored");

  a_unity_pass: assert property (@(posedge sys_clk) disable iff (!rstn) // R01
    gain_r[ch_addr] == GAIN_RST && off_r[ch_addr] == OFF_RST
      |-> calc_code == code_r[ch_addr])
    else $error("unity gain and zero offset changed the code");

  a_load_copy: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    !load_s2 |=> dac_r[0] == $past(corr_r[0]) && dac_r[CHANNELS-1] ==
      $past(corr_r[CHANNELS-1]))
    else $error("outputs not updated under load");

  a_hold_no_load: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    load_s2 |=> $stable(dac_code))
    else $error("outputs moved without load");

  a_load_latency: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    $fell(load_s1) |=> !load_s2)
    else $error("load pin not seen after two flops");

  a_special_pulse: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
    special_strobe |=> !special_strobe)
    else $error("special strobe longer than one cycle");

  a_offset_route: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
    wr_ok && sel_w == SEL_OFFSET |=> off_r[$past(ch_addr)] == $past(data_w))
    else $error("offset not stored at addressed channel");

  a_gain_route: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
    wr_ok && sel_w == SEL_GAIN |=> gain_r[$past(ch_addr)][RES-1:1] == $past(data_w[RES-1:1]))
    else $error("gain not stored at addressed channel");

  a_read_ignored: assert property (@(posedge sys_clk) disable iff (!rstn) // R17
    state_r == ST_WRITE && !is_write |=> $stable(code_r[ch_addr]))
    else $error("read word changed an input code");

endmodule : dac_front

`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host serial controller; its clock stands high outside frames
module host_model
(
  output logic sclk,
  output logic frame_sync_n,
  output logic serial_data
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels from time zero
  initial
  begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    serial_data = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sends the top nbits of w; fewer than 24 makes a bad frame
  task automatic send(input logic [23:0] w, input int nbits);
    #37 frame_sync_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      serial_data = w[23-i];
      #62 sclk = 1'b0;
      #63 sclk = 1'b1;
    end
    #40 frame_sync_n = 1'b1;
    // Stale bit inverted so a late sample cannot pass by luck
    serial_data = ~serial_data;
    #1000;
  endtask : send
endmodule : host_model

`default_nettype wire

// >>> tb/dac_gain_offset_correction_test.sv
`timescale 1ns/1ns
`default_nettype none

module test_dac_gain_offset_correction;
  import dac_pkg::*;
  localparam int RES = 14;
  localparam int CH = 16;
  logic sys_clk;
  logic rstn;
  logic iface_select;
  logic load_outputs_n;
  wire sclk;
  wire frame_sync_n;
  wire serial_data;
  logic [CH*RES-1:0] dac_code;
  logic serial_mode;
  logic special_strobe;
  logic [3:0] special_addr;
  logic [RES-1:0] special_data;
  int failures;
  int checks;
  int sp_cnt;
  logic [3:0] sp_addr;
  logic [RES-1:0] sp_data;
  logic [RES-1:0] code_m [CH];
  logic [RES-1:0] gain_m [CH];
  logic [RES-1:0] off_m [CH];
  logic [RES-1:0] out_m [CH];

  dac_front #(.RES(RES), .CHANNELS(CH)) dut
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sclk(sclk),
    .frame_sync_n(frame_sync_n),
    .serial_data(serial_data),
    .iface_select(iface_select),
    .load_outputs_n(load_outputs_n),
    .dac_code(dac_code),
    .serial_mode(serial_mode),
    .special_strobe(special_strobe),
    .special_addr(special_addr),
    .special_data(special_data)
  );

  host_model host
  (
    .sclk(sclk),
    .frame_sync_n(frame_sync_n),
    .serial_data(serial_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Strobe lasts one cycle; sampled mid-cycle, clear of the edge that launches it
  always @(negedge sys_clk)
  begin
    if (special_strobe === 1'b1)
    begin
      sp_cnt++;
      sp_addr = special_addr;
      sp_data = special_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expected corrected code; wide arithmetic so clamping sees true overflow
  function automatic logic [RES-1:0] corr(input logic [RES-1:0] c, g, o);
    longint r;
    r = ((longint'(c) * (longint'(g) + 2)) >> RES) + longint'(o) - (64'sd1 << (RES-1));
    if (r < 0) r = 0;
    if (r > (64'sd1 << RES) - 1) r = (64'sd1 << RES) - 1;
    return r[RES-1:0];
  endfunction : corr

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // One serial word, then the model follows what the device should accept
  task automatic wr(input logic [3:0] ch, input reg_sel_t sel, input logic [RES-1:0] d,
                    input logic rw, input int nbits);
    logic ok;
    int n0;
    n0 = sp_cnt;
    ok = (nbits == 24) && !rw && iface_select;
    host.send({1'($urandom), rw, 2'b00, ch, sel, d}, nbits);
    repeat (8) @(negedge sys_clk);
    if (ok && sel == SEL_INPUT) code_m[ch] = d;
    if (ok && sel == SEL_OFFSET) off_m[ch] = d;
    if (ok && sel == SEL_GAIN) gain_m[ch] = {d[RES-1:1], 1'b0};
    check("special count", sp_cnt, n0 + int'(ok && sel == SEL_SPECIAL));
    if (ok && sel == SEL_SPECIAL)
    begin
      check("special addr", sp_addr, ch);
      check("special data", sp_data, d);
    end
  endtask : wr

  // Outputs hold until load, then all channels change together
  task automatic load_all();
    for (int k = 0; k < CH; k++) check("held", dac_code[k*RES +: RES], out_m[k]);
    load_outputs_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    load_outputs_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    for (int k = 0; k < CH; k++)
    begin
      out_m[k] = corr(code_m[k], gain_m[k], off_m[k]);
      check("dac_code", dac_code[k*RES +: RES], out_m[k]);
    end
  endtask : load_all

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run of about 250 us
  initial
  begin
    #3000000;
    failures++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(32'hdc60));
    rstn = 1'b0;
    iface_select = 1'b1;
    load_outputs_n = 1'b1;
    failures = 0;
    checks = 0;
    sp_cnt = 0;
    for (int k = 0; k < CH; k++)
    begin
      code_m[k] = '0;
      gain_m[k] = 14'h3FFE;
      off_m[k] = 14'h2000;
      out_m[k] = '0;
    end
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("serial_mode", serial_mode, 1'b1);
    // Default coefficients pass codes unchanged
    wr(4'h0, SEL_INPUT, 14'h3FFF, 1'b0, 24);
    wr(4'h1, SEL_INPUT, 14'h1234, 1'b0, 24);
    load_all();
    // Clamp at both ends, zero gain, odd gain written
    wr(4'h2, SEL_INPUT, 14'h3FFF, 1'b0, 24);
    wr(4'h2, SEL_OFFSET, 14'h3FFF, 1'b0, 24);
    wr(4'h3, SEL_INPUT, 14'h0100, 1'b0, 24);
    wr(4'h3, SEL_OFFSET, 14'h0000, 1'b0, 24);
    wr(4'h4, SEL_INPUT, 14'h2000, 1'b0, 24);
    wr(4'h4, SEL_GAIN, 14'h0000, 1'b0, 24);
    wr(4'h5, SEL_INPUT, 14'h3FFF, 1'b0, 24);
    wr(4'h5, SEL_GAIN, 14'h2FFF, 1'b0, 24);
    load_all();
    // Read word, short frame, two-wire mode: all ignored; then a special word is accepted
    wr(4'h6, SEL_INPUT, 14'h0AAA, 1'b1, 24);
    wr(4'h6, SEL_INPUT, 14'h0555, 1'b0, 20);
    iface_select = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("serial_mode", serial_mode, 1'b0);
    wr(4'h7, SEL_INPUT, 14'h1111, 1'b0, 24);
    iface_select = 1'b1;
    repeat (4) @(negedge sys_clk);
    wr(4'h9, SEL_SPECIAL, 14'h1ABC, 1'b0, 24);
    load_all();
    // Random traffic: 32 words over randomly drawn select codes and channels
    for (int i = 0; i < 32; i++)
    begin
      wr(4'($urandom), reg_sel_t'(2'($urandom)), 14'($urandom), 1'b0, 24);
      if (i % 8 == 7) load_all();
    end
    stop_test();
  end
endmodule : test_dac_gain_offset_correction

`default_nettype wire
